// File: src/irq_input_map.vh
`ifndef IRQ_INPUT_MAP_VH
`define IRQ_INPUT_MAP_VH
// ==================================================================
// Register offsets (word index on the plain register port)
`define REG_COMMAND      4'h0
`define REG_CMD_STATUS   4'h1
`define REG_EDGE_STATE   4'h2
`define REG_MODE_STATE   4'h3
`define REG_IRQ_STATUS   4'h4
`define REG_IRQ_ENABLE   4'h5
`define REG_IRQ_CLEAR    4'h6
`define REG_SETVAL_BASE  4'h8
// ==================================================================
// Command word fields: [31:16] identifier, [15:0] code
`define CMD_ID_HI        31
`define CMD_ID_LO        16
`define CMD_CODE_HI      15
`define CMD_CODE_LO      0
// Command identifiers
`define ID_ENABLE_BASE   16'd100
`define ID_EDGE_BASE     16'd110
`define ID_READ_BASE     16'd120
// Codes
`define CODE_EDGE_ON     16'h0000
`define CODE_EDGE_OFF    16'h0001
`define CODE_DIRECT      16'h0000
`define CODE_DISABLE     16'h0001
`define CODE_COUNT_DN    16'h0002
`define CODE_COUNT_UP    16'h0003
// Mode encodings
`define MODE_DISABLED    2'h0
`define MODE_DIRECT      2'h1
`define MODE_DOWN        2'h2
`define MODE_UP          2'h3
// Task numbers
`define TASK_BASE        8'd140
// Reset values
`define COUNT_RESET      16'h0000
`define SETVAL_RESET     16'h0000
`endif

// File: src/irq_input_block.v
// Behaviour
// - Inputs 0..7 each start their own task, numbered 140 to 147.
// - Edge command ids 110..117; code 0 detects ON, 1 detects OFF.
// - Enable ids 100..107; code 0 direct mode, code 1 disables.
// - Enable code 2 is down counter mode, code 3 up counter mode.
// - Without an edge command, use the stored startup edge setting.
// - Count readable from refreshed status or immediate read command.
// - Up count hits set value -> 0 plus task; down hits 0 -> reload.
// - Enabling counter mode presets the present count.
`timescale 1ns/1ps
`include "irq_input_map.vh"
module irq_input_block (
  input  wire        i_clock,       // 20 MHz clock
  input  wire        i_rstn,        // Async reset, active low
  input  wire [7:0]  i_lines,       // Interrupt lines 0..7
  input  wire [7:0]  i_startup_edge,// Stored startup edge, 1 = OFF edge
  input  wire        i_io_refresh,  // I/O refresh pulse
  input  wire [3:0]  i_addr,        // Register word index
  input  wire [31:0] i_wdata,       // Write data
  input  wire        i_wr,          // Write strobe
  input  wire        i_rd,          // Read strobe
  output reg  [31:0] o_rdata,       // Read data, cycle after read strobe
  output reg         o_task_valid,  // Task start pulse
  output reg  [7:0]  o_task_number, // Task number started
  output reg  [7:0]  o_task_start,  // Per-input task start pulses
  output reg  [15:0] o_read_value,  // Immediate read result
  output reg         o_read_valid,  // Immediate read result pulse
  output reg         o_irq          // Level interrupt
);

  // ================================================================
  // State
  reg  [7:0]   lines_reg;
  reg          edge_loaded_reg;
  reg  [7:0]   edge_reg;            // 1 = detect OFF transition
  reg  [15:0]  mode_reg;            // Two bits per input
  reg  [15:0]  count_reg [0:7];     // Present count per input
  reg  [15:0]  setval_reg [0:7];    // Set value per input
  reg  [15:0]  status_pv_reg [0:7]; // Refreshed count copies
  reg  [7:0]   irq_status_reg;
  reg  [7:0]   irq_enable_reg;
  reg  [1:0]   cmd_err_reg;         // [0] bad id, [1] bad code
  integer      k;

  // Command decode
  wire [15:0]  cmd_id   = i_wdata[`CMD_ID_HI:`CMD_ID_LO];
  wire [15:0]  cmd_code = i_wdata[`CMD_CODE_HI:`CMD_CODE_LO];
  wire         cmd_wr   = i_wr && (i_addr == `REG_COMMAND);

  // Index of an id within an 8-wide group, or 8 when outside it
  function [3:0] id_index;
    input [15:0] id;
    input [15:0] base;
    begin
      if (id >= base && id < base + 16'd8)
        id_index = {1'b0, id[2:0] - base[2:0]};
      else
        id_index = 4'h8;
    end
  endfunction

  wire [3:0] en_idx = id_index(cmd_id, `ID_ENABLE_BASE);
  wire [3:0] ed_idx = id_index(cmd_id, `ID_EDGE_BASE);
  wire [3:0] rd_idx = id_index(cmd_id, `ID_READ_BASE);

  // ================================================================
  // Edge detection, per configured edge
  wire [7:0] rise = i_lines & ~lines_reg;
  wire [7:0] fall = ~i_lines & lines_reg;
  wire [7:0] hit  = (rise & ~edge_reg) | (fall & edge_reg);

  // Per-input trigger and next count
  reg  [7:0]  fire;
  reg  [15:0] cnt_next [0:7];
  reg  [1:0]  md;
  integer     j;
  always @* begin
    md = `MODE_DISABLED;
    for (j = 0; j < 8; j = j + 1) begin
      md = mode_reg[2*j +: 2];
      fire[j] = 1'b0;
      cnt_next[j] = count_reg[j];
      if (hit[j]) begin
        case (md)
          `MODE_DIRECT: fire[j] = 1'b1;
          `MODE_UP: begin
            if (count_reg[j] + 16'd1 >= setval_reg[j]) begin
              cnt_next[j] = 16'h0000;
              fire[j] = 1'b1;
            end else
              cnt_next[j] = count_reg[j] + 16'd1;
          end
          `MODE_DOWN: begin
            if (count_reg[j] <= 16'd1) begin
              cnt_next[j] = setval_reg[j];
              fire[j] = 1'b1;
            end else
              cnt_next[j] = count_reg[j] - 16'd1;
          end
          default: fire[j] = 1'b0;
        endcase
      end
    end
  end

  // Lowest firing input reported on the numbered task port
  // Own loop index, so each combinational process drives only its own
  reg [2:0] first_idx;
  integer   m;
  always @* begin
    first_idx = 3'h0;
    for (m = 7; m >= 0; m = m - 1)
      if (fire[m])
        first_idx = m[2:0];
  end

  // ================================================================
  // Configuration, counters and tasks
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      lines_reg       <= 8'h00;
      edge_loaded_reg <= 1'b0;
      edge_reg        <= 8'h00;
      mode_reg        <= 16'h0000;
      cmd_err_reg     <= 2'h0;
      o_task_valid    <= 1'b0;
      o_task_number   <= 8'h00;
      o_task_start    <= 8'h00;
      o_read_value    <= 16'h0000;
      o_read_valid    <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        count_reg[k]     <= `COUNT_RESET;
        setval_reg[k]    <= `SETVAL_RESET;
        status_pv_reg[k] <= `COUNT_RESET;
      end
    end else begin
      lines_reg    <= i_lines;
      o_task_start <= fire;
      o_task_valid <= |fire;
      o_task_number <= `TASK_BASE + {5'h00, first_idx};
      o_read_valid <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        count_reg[k] <= cnt_next[k];
        if (i_io_refresh)
          status_pv_reg[k] <= cnt_next[k];
        if (i_wr && i_addr == `REG_SETVAL_BASE + k[3:0] - 4'h8 + 4'h8
            && k < 8 && i_addr[3])
          setval_reg[k] <= i_wdata[15:0];
      end
      // Startup edge caught after reset release
      if (!edge_loaded_reg) begin
        edge_loaded_reg <= 1'b1;
        edge_reg        <= i_startup_edge;
      end
      // One command per write; each issued once by the program
      if (cmd_wr) begin
        cmd_err_reg <= 2'h0;
        if (ed_idx != 4'h8) begin
          if (cmd_code == `CODE_EDGE_ON)
            edge_reg[ed_idx[2:0]] <= 1'b0;
          else if (cmd_code == `CODE_EDGE_OFF)
            edge_reg[ed_idx[2:0]] <= 1'b1;
          else
            cmd_err_reg <= 2'h2;
        end else if (en_idx != 4'h8) begin
          case (cmd_code)
            `CODE_DIRECT:
              mode_reg[2*en_idx[2:0] +: 2] <= `MODE_DIRECT;
            `CODE_DISABLE:
              mode_reg[2*en_idx[2:0] +: 2] <= `MODE_DISABLED;
            `CODE_COUNT_DN: begin
              mode_reg[2*en_idx[2:0] +: 2] <= `MODE_DOWN;
              count_reg[en_idx[2:0]] <= setval_reg[en_idx[2:0]];
            end
            `CODE_COUNT_UP: begin
              mode_reg[2*en_idx[2:0] +: 2] <= `MODE_UP;
              count_reg[en_idx[2:0]] <= 16'h0000;
            end
            default: cmd_err_reg <= 2'h2;
          endcase
        end else if (rd_idx != 4'h8) begin
          o_read_value <= count_reg[rd_idx[2:0]];
          o_read_valid <= 1'b1;
        end else
          cmd_err_reg <= 2'h1;
      end
    end
  end

  // ================================================================
  // Interrupt status, enable and clear; set wins over clear
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_status_reg <= 8'h00;
      irq_enable_reg <= 8'h00;
      o_irq          <= 1'b0;
    end else begin
      if (i_wr && i_addr == `REG_IRQ_ENABLE)
        irq_enable_reg <= i_wdata[7:0];
      if (i_wr && i_addr == `REG_IRQ_CLEAR)
        irq_status_reg <= (irq_status_reg & ~i_wdata[7:0]) | fire;
      else
        irq_status_reg <= irq_status_reg | fire;
      o_irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // ================================================================
  // Register read port, data one cycle after the strobe
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn)
      o_rdata <= 32'h0000_0000;
    else if (i_rd) begin
      if (i_addr[3])
        o_rdata <= {status_pv_reg[i_addr[2:0]], setval_reg[i_addr[2:0]]};
      else begin
        case (i_addr)
          `REG_CMD_STATUS: o_rdata <= {30'h0, cmd_err_reg};
          `REG_EDGE_STATE: o_rdata <= {24'h0, edge_reg};
          `REG_MODE_STATE: o_rdata <= {16'h0, mode_reg};
          `REG_IRQ_STATUS: o_rdata <= {24'h0, irq_status_reg};
          `REG_IRQ_ENABLE: o_rdata <= {24'h0, irq_enable_reg};
          default:         o_rdata <= 32'h0000_0000;
        endcase
      end
    end else
      o_rdata <= 32'h0000_0000;
  end

endmodule // irq_input_block

// File: tb/irq_input_checker.sv
`timescale 1ns/1ps
`include "irq_input_map.vh"
// ==================================================================
// Port checker
module irq_input_checker (
  input wire        i_clock,       // Clock
  input wire        i_rstn,        // Reset, active low
  input wire [7:0]  i_lines,       // Input lines
  input wire [3:0]  i_addr,        // Word index
  input wire [31:0] i_wdata,       // Write data
  input wire        i_wr,          // Write strobe
  input wire        i_rd,          // Read strobe
  input wire [31:0] o_rdata,       // Read data
  input wire        o_task_valid,  // Task pulse
  input wire [7:0]  o_task_number, // Task number
  input wire [7:0]  o_task_start,  // Task pulses
  input wire        o_read_valid   // Immediate read pulse
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Task numbering
  a_task_range:
    assert property (o_task_valid |-> o_task_number inside {[8'h8C:8'h93]})
    else $error("task number out of range");
  a_valid_match:
    assert property (o_task_valid == (o_task_start != 8'h00))
    else $error("task pulse and starts disagree");
  a_first_task:
    assert property (o_task_start[0] |-> o_task_number == 8'h8C)
    else $error("input 0 task number wrong");
  a_last_task:
    assert property (o_task_start == 8'h80 |-> o_task_number == 8'h93)
    else $error("input 7 task number wrong");
  // Read paths
  a_rdata_idle:
    assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside read slot");
  a_read_cause:
    assert property (o_read_valid |-> $past(i_wr && i_addr == `REG_COMMAND
      && i_wdata[31:16] >= 16'd120 && i_wdata[31:16] <= 16'd127))
    else $error("immediate read without command");
  // Tasks only from a fresh edge
  a_no_repeat:
    assert property (o_task_valid |=> (o_task_start & $past(o_task_start))
      == 8'h00) else $error("task repeated without edge");
  a_task_edge:
    assert property (o_task_valid |-> (o_task_start & ~(($past(i_lines)
      ^ $past(i_lines, 2)) | ($past(i_lines, 2) ^ $past(i_lines, 3))))
      == 8'h00) else $error("task without line change");
  c_task: cover property (o_task_valid);
  c_read: cover property (o_read_valid);
  c_last: cover property (o_task_start[7]);
endmodule // irq_input_checker

bind irq_input_block irq_input_checker chk (.i_clock, .i_rstn, .i_lines,
  .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_task_valid,
  .o_task_number, .o_task_start, .o_read_valid);

// File: tb/line_source.sv
`timescale 1ns/1ps
// ==================================================================
// External line model
module line_source (
  input  wire       i_clock,  // Clock
  input  wire [7:0] i_toggle, // Lines to flip
  output reg  [7:0] o_lines   // Driven lines
);
  // Lines flip just after the edge, one flip per request
  initial o_lines = 8'h00;
  always @(posedge i_clock) begin
    o_lines <= o_lines ^ i_toggle;
  end
endmodule // line_source

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "irq_input_map.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
// ==================================================================
// Bench top
module testbench;
  reg         i_clock = 0, i_rstn = 0, i_io_refresh = 0, i_wr = 0, i_rd = 0;
  reg  [7:0]  i_startup_edge = 0, tog = 0;
  reg  [3:0]  i_addr = 0;
  reg  [31:0] i_wdata = 0;
  reg         rd_d = 0;
  wire [7:0]  i_lines, o_task_number, o_task_start;
  wire [31:0] o_rdata;
  wire [15:0] o_read_value;
  wire        o_task_valid, o_read_valid, o_irq;
  integer     seed = 10967, error_cnt = 0, n_checks = 0, i, n;
  reg  [31:0] qr[$];
  reg  [7:0]  qt[$];
  reg  [15:0] qv[$];
  line_source partner (.i_clock(i_clock), .i_toggle(tog), .o_lines(i_lines));
  irq_input_block dut (.i_clock(i_clock), .i_rstn(i_rstn),
    .i_lines(i_lines), .i_startup_edge(i_startup_edge),
    .i_io_refresh(i_io_refresh), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_task_valid(o_task_valid), .o_task_number(o_task_number),
    .o_task_start(o_task_start), .o_read_value(o_read_value),
    .o_read_valid(o_read_valid), .o_irq(o_irq));
  // Clock
  initial forever #25 i_clock = ~i_clock;
  task report_and_stop;
    begin
      if (error_cnt == 0 && n_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  // Bus cycles, one strobe cycle each
  task wr(input [3:0] a, input [31:0] d);
    begin
      @(posedge i_clock); i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
      @(posedge i_clock); i_wr <= 1'b0;
    end
  endtask
  task rd(input [3:0] a, input [31:0] e);
    begin
      qr.push_back(e);
      @(posedge i_clock); i_rd <= 1'b1; i_addr <= a;
      @(posedge i_clock); i_rd <= 1'b0;
    end
  endtask
  task cmd(input [15:0] id, input [15:0] c);
    wr(`REG_COMMAND, {id, c}); // Single write pulse
  endtask
  // Flip line k once, noting the task it must start
  task flip(input integer k, input f);
    begin
      if (f) qt.push_back(`TASK_BASE + k);
      @(posedge i_clock); tog <= 8'h01 << k;
      @(posedge i_clock); tog <= 8'h00;
      repeat (4) @(posedge i_clock);
    end
  endtask
  task refresh;
    begin
      @(posedge i_clock); i_io_refresh <= 1'b1;
      @(posedge i_clock); i_io_refresh <= 1'b0;
    end
  endtask
  task wait_irq(input v);
    integer t;
    begin
      for (t = 0; t < 20 && o_irq !== v; t++) @(posedge i_clock);
      `CHK(o_irq, v)
      if (o_irq !== v) report_and_stop;
    end
  endtask
  // Result watcher, oldest note first
  // Peek the note, compare, then drop it; an empty queue gives a mismatch
  always @(posedge i_clock) begin
    rd_d <= i_rd;
    if (rd_d) begin
      `CHK(o_rdata, qr[0])
      void'(qr.pop_front());
    end
    if (o_task_valid === 1'b1) begin
      `CHK(o_task_number, qt[0])
      `CHK(o_task_start, 8'h01 << (qt[0] - `TASK_BASE))
      void'(qt.pop_front());
    end
    if (o_read_valid === 1'b1) begin
      `CHK(o_read_value, qv[0])
      void'(qv.pop_front());
    end
  end
  // Main sequence
  initial begin
    i_startup_edge <= 8'($random(seed));
    repeat (5) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (2) @(posedge i_clock);
    rd(`REG_EDGE_STATE, {24'h0, i_startup_edge});
    rd(`REG_MODE_STATE, 32'h0);
    rd(4'h7, 32'h0);
    for (n = 0; n < 8; n++) begin
      cmd(`ID_ENABLE_BASE + 16'(n), `CODE_DIRECT);
      flip(n, !i_startup_edge[n]);
      flip(n, i_startup_edge[n]);
    end
    rd(`REG_MODE_STATE, 32'h5555);
    for (n = 0; n < 8; n++) begin
      cmd(`ID_EDGE_BASE + 16'(n), `CODE_EDGE_OFF);
      flip(n, 1'b0);
      flip(n, 1'b1);
    end
    rd(`REG_EDGE_STATE, 32'hFF);
    cmd(`ID_EDGE_BASE, `CODE_EDGE_ON);
    cmd(`ID_EDGE_BASE + 16'd1, `CODE_EDGE_ON);
    // Up counter, set value 3
    wr(`REG_SETVAL_BASE, 32'h3);
    cmd(`ID_ENABLE_BASE, `CODE_COUNT_UP);
    for (i = 1; i <= 7; i++) begin
      flip(0, i % 3 == 0);
      flip(0, 1'b0);
    end
    refresh;
    rd(`REG_SETVAL_BASE, {16'd1, 16'd3});
    qv.push_back(16'd1);
    cmd(`ID_READ_BASE, 16'h0);
    cmd(`ID_ENABLE_BASE, `CODE_COUNT_UP);
    refresh;
    rd(`REG_SETVAL_BASE, {16'd0, 16'd3});
    // Down counter, set value 2, then disabled
    wr(`REG_SETVAL_BASE + 4'h1, 32'h2);
    cmd(`ID_ENABLE_BASE + 16'd1, `CODE_COUNT_DN);
    refresh;
    rd(`REG_SETVAL_BASE + 4'h1, {16'd2, 16'd2});
    for (i = 1; i <= 5; i++) begin
      flip(1, i % 2 == 0 && i < 5);
      flip(1, 1'b0);
    end
    cmd(`ID_ENABLE_BASE + 16'd1, `CODE_DISABLE);
    flip(1, 1'b0);
    flip(1, 1'b0);
    refresh;
    rd(`REG_SETVAL_BASE + 4'h1, {16'd1, 16'd2});
    // Interrupt raise, mask and clear
    rd(`REG_IRQ_STATUS, 32'hFF);
    wr(`REG_IRQ_ENABLE, 32'h2);
    wait_irq(1'b1);
    wr(`REG_IRQ_CLEAR, 32'h2);
    wait_irq(1'b0);
    rd(`REG_IRQ_STATUS, 32'hFD);
    wr(`REG_IRQ_CLEAR, 32'hFF);
    wr(`REG_IRQ_ENABLE, 32'h1);
    rd(`REG_IRQ_ENABLE, 32'h1);
    cmd(`ID_ENABLE_BASE, `CODE_DIRECT);
    flip(0, 1'b1);
    wait_irq(1'b1);
    cmd(16'd99, 16'h0);
    rd(`REG_CMD_STATUS, 32'h1);
    // Let the watcher see the last read data before the verdict
    repeat (3) @(posedge i_clock);
    `CHK(qt.size(), 0)
    report_and_stop;
  end
endmodule // testbench
